//--- rtl/apmc_pkg.sv
// Constants, register map and field positions of the audio power/misc control block.
// Assumes a 125 MHz system clock and a 32-bit classic Wishbone register bus.
package apmc_pkg;

  localparam longint unsigned APMC_CLK_FREQ_HZ = 64'd125000000;

  // Common-mode reference slow start
  localparam longint unsigned APMC_VCM_STARTUP_MS = 64'd500;
  localparam int unsigned APMC_VCM_STARTUP_CYCLES =
    32'((APMC_VCM_STARTUP_MS * APMC_CLK_FREQ_HZ) / 64'd1000);
  // Settling time granted to any other power transition
  localparam longint unsigned APMC_SETTLE_NS = 64'd1000;
  localparam int unsigned APMC_SETTLE_CYCLES =
    32'((APMC_SETTLE_NS * APMC_CLK_FREQ_HZ) / 64'd1000000000);

  localparam int APMC_CNT_W = 26;
  localparam int APMC_ADR_W = 8;
  localparam int APMC_IDX_W = 6;

  // Register indices; byte address is four times the index
  localparam logic [APMC_IDX_W-1:0] APMC_IDX_POWER_CTRL = 6'h05;
  localparam logic [APMC_IDX_W-1:0] APMC_IDX_AUX_STATUS = 6'h06;

  // Field positions of the power/misc control register
  localparam int APMC_BIT_ALL_PD = 15;
  localparam int APMC_BIT_CM_PD = 14;
  localparam int APMC_BIT_BYPASS_PD = 13;
  localparam int APMC_BIT_HP_PD = 12;
  localparam int APMC_BIT_MONO_PD = 11;
  localparam int APMC_BIT_DAC_PD = 10;
  localparam int APMC_BIT_ADC_PD = 9;
  localparam int APMC_BIT_RSVD8 = 8;
  localparam int APMC_BIT_PWR_DONE = 7;
  localparam int APMC_BIT_MICBIAS_PD = 6;
  localparam int APMC_BIT_OSC_EN = 5;
  localparam int APMC_BIT_CLKBUF_EN = 4;
  localparam int APMC_BIT_SYNC_PD = 3;
  localparam int APMC_BIT_UNSYNCED = 2;
  localparam int APMC_BIT_EFFECTS_EN = 1;
  localparam int APMC_BIT_DEEMPH_EN = 0;
  // Field of the auxiliary status register
  localparam int APMC_BIT_VOL_STEP_DONE = 0;

  // Writable bits and their reset image
  localparam logic [15:0] APMC_CTRL_WMASK = 16'hFF7B;
  localparam logic [15:0] APMC_CTRL_RESET = 16'hFF20;

  // Sync monitor frame counter
  localparam int APMC_BCNT_W = 8;
  localparam logic [APMC_BCNT_W-1:0] APMC_BCNT_MAX = 8'hFF;

endpackage

//--- rtl/apmc_sync_monitor.sv
// Serial audio clock sync monitor: counts bit clocks per frame clock period.
// Assumes LRCLK and BCLK arrive asynchronously from pins and are far slower
// than the system clock.
`timescale 1ns/1ps
module apmc_sync_monitor
  import apmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_enable,
  input wire logic i_lrclk,
  input wire logic i_bclk,
  output logic o_unsynced
);

  typedef struct packed {
    logic lr_s1;
    logic lr_s2;
    logic lr_s3;
    logic bc_s1;
    logic bc_s2;
    logic bc_s3;
    logic [APMC_BCNT_W-1:0] count;
    logic [APMC_BCNT_W-1:0] last;
    logic last_valid;
    logic unsynced;
  } apmc_mon_t;

  localparam apmc_mon_t MON_RESET = '0;

  apmc_mon_t mon_q;
  apmc_mon_t mon_d;

  always_comb begin
    mon_d = mon_q;
    mon_d.lr_s1 = i_lrclk;
    mon_d.lr_s2 = mon_q.lr_s1;
    mon_d.lr_s3 = mon_q.lr_s2;
    mon_d.bc_s1 = i_bclk;
    mon_d.bc_s2 = mon_q.bc_s1;
    mon_d.bc_s3 = mon_q.bc_s2;
    if (!i_enable) begin
      // Disabled monitor forgets history so it never flags
      mon_d.count = '0;
      mon_d.last = '0;
      mon_d.last_valid = 1'b0;
      mon_d.unsynced = 1'b0;
    end else begin
      if (mon_q.bc_s2 && !mon_q.bc_s3 && mon_q.count != APMC_BCNT_MAX) begin
        mon_d.count = mon_q.count + 1'b1;
      end
      if (mon_q.lr_s2 && !mon_q.lr_s3) begin
        // Bit clocks per frame must repeat; a change means slipped clocks
        if (mon_q.last_valid) begin
          mon_d.unsynced = (mon_q.count != mon_q.last);
        end
        mon_d.last = mon_q.count;
        mon_d.last_valid = 1'b1;
        mon_d.count = '0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mon_q <= MON_RESET;
    end else begin
      mon_q <= mon_d;
    end
  end

  assign o_unsynced = mon_q.unsynced;

endmodule

//--- rtl/apmc_top.sv
// Audio power and miscellaneous control register with power sequencing.
// Assumes a classic Wishbone master on the system clock and serial audio
// clocks arriving asynchronously on pins.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps

// Summary of operation
// - Bits 15 and 13..9 power their section down when 1, up when 0; bit 14 selects the common-mode mode; bit 8 is reserved.
// - Master power-down bit overrides bits 14..9 and 6; resets to 1.
// - Master bit leaves other bits intact; sections then follow own bits.
// - Common-mode bit 1: reference on only while a path needs it.
// - Common-mode bit 0: reference stays on once started, avoiding 500 ms start.
// - Bypass, headphone, DAC bits: 0 powers up, 1 down; reset 1.
// - Mono driver up also powers the input path, converters stay off.
// - ADC up also powers the input path.
// - Bit 7 reads 1 when power transitions finish, 0 while pending.
// - Bit 6 turns microphone bias on at 0 (reset), off at 1.
// - Bit 5 turns the oscillator on at 1 (reset), nothing depends on it.
// - Bit 4 drives buffered oscillator clock to the shared pin; reset 0.
// - Bit 3 enables the serial clock sync monitor at 0 (reset).
// - Detected sync loss halts the converters until resynchronised.
// - Bit 2 sticky unsynced flag, resets 1, cleared by reading.
// - Bit 1 enables the effects filter; reset 0 passes samples unfiltered.
// - Bit 0 enables de-emphasis; reset off.
// - Read-only volume soft-step flag, 0 while stepping, resets 1.
// - All audio blocks start powered down; software must power them up.
module apmc_top
  import apmc_pkg::*;
#(
  parameter int unsigned VCM_STARTUP_CYCLES = APMC_VCM_STARTUP_CYCLES
)
(
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [APMC_ADR_W-1:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic I_LRCLK,
  input wire logic I_BCLK,
  input wire logic I_VOL_STEP_BUSY,
  output logic O_BYPASS_PWR_EN,
  output logic O_HP_AMP_PWR_EN,
  output logic O_MONO_PWR_EN,
  output logic O_DAC_PWR_EN,
  output logic O_ADC_PWR_EN,
  output logic O_INPUT_PATH_PWR_EN,
  output logic O_VCM_PWR_EN,
  output logic O_MIC_BIAS_EN,
  output logic O_OSC_EN,
  output logic O_CLKBUF_EN,
  output logic O_EFFECTS_EN,
  output logic O_DEEMPH_EN,
  output logic O_CONV_HALT
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic unsynced;
    logic vol_done;
    logic vcm_hold;
    logic [APMC_CNT_W-1:0] settle;
    logic bypass_en;
    logic hp_en;
    logic mono_en;
    logic dac_en;
    logic adc_en;
    logic input_en;
    logic vcm_en;
    logic mic_en;
    logic osc_en;
    logic clkbuf_en;
    logic effects_en;
    logic deemph_en;
    logic halt;
    logic ack;
    logic [31:0] rdata;
  } apmc_state_t;

  localparam apmc_state_t STATE_RESET = '{
    ctrl: APMC_CTRL_RESET,
    unsynced: 1'b1,
    vol_done: 1'b1,
    vcm_hold: 1'b0,
    settle: '0,
    bypass_en: 1'b0,
    hp_en: 1'b0,
    mono_en: 1'b0,
    dac_en: 1'b0,
    adc_en: 1'b0,
    input_en: 1'b0,
    vcm_en: 1'b0,
    mic_en: 1'b0,
    osc_en: 1'b1,
    clkbuf_en: 1'b0,
    effects_en: 1'b0,
    deemph_en: 1'b0,
    halt: 1'b0,
    ack: 1'b0,
    rdata: '0
  };

  localparam logic [APMC_CNT_W-1:0] SETTLE_LOAD = APMC_CNT_W'(APMC_SETTLE_CYCLES);
  localparam logic [APMC_CNT_W-1:0] VCM_LOAD = APMC_CNT_W'(VCM_STARTUP_CYCLES);

  apmc_state_t st_q;
  apmc_state_t st_d;
  logic mon_unsynced;

  function automatic logic reg_hit(input logic [APMC_ADR_W-1:0] adr,
                                   input logic [APMC_IDX_W-1:0] idx);
    reg_hit = (adr[APMC_ADR_W-1:2] == idx);
  endfunction

  // Master power-down overrides every section bit
  function automatic logic section_up(input logic master_pd,
                                      input logic own_pd);
    section_up = !master_pd && !own_pd;
  endfunction

  apmc_sync_monitor u_sync_monitor (
    .i_clk(I_CLK_SYS),
    .i_reset_n(I_RESET_N),
    .i_enable(!st_q.ctrl[APMC_BIT_SYNC_PD]),
    .i_lrclk(I_LRCLK),
    .i_bclk(I_BCLK),
    .o_unsynced(mon_unsynced)
  );

  always_comb begin
    logic req;
    logic wr_ctrl;
    logic rd_ctrl;
    logic all_pd;
    logic path_need;
    logic [15:0] ctrl_img;
    logic [15:0] wr_val;
    logic [15:0] wr_lane;
    req = 1'b0;
    wr_ctrl = 1'b0;
    rd_ctrl = 1'b0;
    all_pd = 1'b0;
    path_need = 1'b0;
    ctrl_img = '0;
    wr_val = '0;
    wr_lane = '0;
    st_d = st_q;

    // Bus: answer one cycle after the request, drop ack the cycle after
    req = I_WB_CYC && I_WB_STB && !st_q.ack;
    st_d.ack = req;
    wr_ctrl = req && I_WB_WE && reg_hit(I_WB_ADR, APMC_IDX_POWER_CTRL);
    rd_ctrl = req && !I_WB_WE && reg_hit(I_WB_ADR, APMC_IDX_POWER_CTRL);

    for (int i = 0; i < 16; i++) begin
      wr_lane[i] = I_WB_SEL[i / 8];
    end
    wr_val = I_WB_DAT[15:0];
    if (wr_ctrl) begin
      // All writable bits of the enabled lanes are stored; masked bits keep their value
      st_d.ctrl = (st_q.ctrl & ~(wr_lane & APMC_CTRL_WMASK)) |
                  (wr_val & wr_lane & APMC_CTRL_WMASK);
    end

    // Read image carries live status in the read-only slots
    ctrl_img = st_q.ctrl;
    ctrl_img[APMC_BIT_PWR_DONE] = (st_q.settle == '0);
    ctrl_img[APMC_BIT_UNSYNCED] = st_q.unsynced;
    if (req && !I_WB_WE) begin
      if (rd_ctrl) begin
        st_d.rdata = {16'h0000, ctrl_img};
      end else if (reg_hit(I_WB_ADR, APMC_IDX_AUX_STATUS)) begin
        st_d.rdata = '0;
        st_d.rdata[APMC_BIT_VOL_STEP_DONE] = st_q.vol_done;
      end else begin
        // Unmapped reads answer zero
        st_d.rdata = '0;
      end
    end

    // Sticky unsynced flag: a new event beats the read clear
    st_d.unsynced = (st_q.unsynced && !rd_ctrl) || mon_unsynced;
    st_d.halt = mon_unsynced;
    st_d.vol_done = !I_VOL_STEP_BUSY;

    // Power decisions from the stored control bits
    all_pd = st_q.ctrl[APMC_BIT_ALL_PD];
    st_d.bypass_en = section_up(all_pd, st_q.ctrl[APMC_BIT_BYPASS_PD]);
    st_d.hp_en = section_up(all_pd, st_q.ctrl[APMC_BIT_HP_PD]);
    st_d.dac_en = section_up(all_pd, st_q.ctrl[APMC_BIT_DAC_PD]);
    st_d.mono_en = section_up(all_pd, st_q.ctrl[APMC_BIT_MONO_PD]);
    st_d.adc_en = section_up(all_pd, st_q.ctrl[APMC_BIT_ADC_PD]);
    st_d.input_en = st_d.mono_en || st_d.adc_en;
    st_d.mic_en = section_up(all_pd, st_q.ctrl[APMC_BIT_MICBIAS_PD]);

    path_need = st_d.bypass_en || st_d.dac_en || st_d.adc_en || st_d.input_en;
    // Held reference trades idle power for no slow restart
    if (all_pd || st_q.ctrl[APMC_BIT_CM_PD]) begin
      st_d.vcm_hold = 1'b0;
    end else if (st_q.vcm_en) begin
      st_d.vcm_hold = 1'b1;
    end
    st_d.vcm_en = path_need || (st_q.vcm_hold && !st_q.ctrl[APMC_BIT_CM_PD] && !all_pd);

    // Misc controls outside the audio power tree
    st_d.osc_en = st_q.ctrl[APMC_BIT_OSC_EN];
    st_d.clkbuf_en = st_q.ctrl[APMC_BIT_CLKBUF_EN];
    st_d.effects_en = st_q.ctrl[APMC_BIT_EFFECTS_EN];
    st_d.deemph_en = st_q.ctrl[APMC_BIT_DEEMPH_EN];

    // Completion timer restarts when the reference powers up, else is extended to at least the settle time on any power change
    if (st_d.vcm_en && !st_q.vcm_en) begin
      st_d.settle = (VCM_LOAD > SETTLE_LOAD) ? VCM_LOAD : SETTLE_LOAD;
    end else if (st_d.bypass_en != st_q.bypass_en || st_d.hp_en != st_q.hp_en ||
                 st_d.mono_en != st_q.mono_en || st_d.dac_en != st_q.dac_en ||
                 st_d.adc_en != st_q.adc_en || st_d.mic_en != st_q.mic_en ||
                 st_d.vcm_en != st_q.vcm_en) begin
      st_d.settle = (st_q.settle > SETTLE_LOAD) ? st_q.settle : SETTLE_LOAD;
    end else if (st_q.settle != '0) begin
      st_d.settle = st_q.settle - 1'b1;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st_q <= STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign O_WB_DAT = st_q.rdata;
  assign O_WB_ACK = st_q.ack;
  assign O_BYPASS_PWR_EN = st_q.bypass_en;
  assign O_HP_AMP_PWR_EN = st_q.hp_en;
  assign O_MONO_PWR_EN = st_q.mono_en;
  assign O_DAC_PWR_EN = st_q.dac_en;
  assign O_ADC_PWR_EN = st_q.adc_en;
  assign O_INPUT_PATH_PWR_EN = st_q.input_en;
  assign O_VCM_PWR_EN = st_q.vcm_en;
  assign O_MIC_BIAS_EN = st_q.mic_en;
  assign O_OSC_EN = st_q.osc_en;
  assign O_CLKBUF_EN = st_q.clkbuf_en;
  assign O_EFFECTS_EN = st_q.effects_en;
  assign O_DEEMPH_EN = st_q.deemph_en;
  assign O_CONV_HALT = st_q.halt;

endmodule

//--- verification/apmc_top_props.sv
// Checker for the audio power control block.
// Assumes control writes go to byte address 0x14.
`timescale 1ns/1ps
module apmc_top_props
  import apmc_pkg::*;
#(
  parameter int unsigned VCM_STARTUP_CYCLES = APMC_VCM_STARTUP_CYCLES
)
(
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [APMC_ADR_W-1:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic O_WB_ACK,
  input wire logic O_BYPASS_PWR_EN,
  input wire logic O_HP_AMP_PWR_EN,
  input wire logic O_MONO_PWR_EN,
  input wire logic O_DAC_PWR_EN,
  input wire logic O_ADC_PWR_EN,
  input wire logic O_INPUT_PATH_PWR_EN,
  input wire logic O_VCM_PWR_EN,
  input wire logic O_MIC_BIAS_EN,
  input wire logic O_OSC_EN,
  input wire logic O_CLKBUF_EN,
  input wire logic O_EFFECTS_EN,
  input wire logic O_DEEMPH_EN,
  input wire logic O_CONV_HALT
);
  logic [15:0] s_q;
  logic nd;
  // Shadow lands with the outputs, one edge after the register
  assign nd = O_BYPASS_PWR_EN | O_DAC_PWR_EN | O_ADC_PWR_EN | O_INPUT_PATH_PWR_EN;
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      s_q <= APMC_CTRL_RESET;
    end else if (O_WB_ACK && I_WB_WE && I_WB_ADR[7:2] == APMC_IDX_POWER_CTRL) begin
      if (I_WB_SEL[0]) s_q[7:0] <= I_WB_DAT[7:0];
      if (I_WB_SEL[1]) s_q[15:8] <= I_WB_DAT[15:8];
    end
  end
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);
  a_ack_next: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("ack late");
  a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack too long");
  a_dac_follow: assert property (O_DAC_PWR_EN == !(s_q[15] | s_q[10]))
    else $error("dac enable wrong");
  a_path_follow: assert property (O_BYPASS_PWR_EN == !(s_q[15] | s_q[13]) &&
    O_HP_AMP_PWR_EN == !(s_q[15] | s_q[12]) && O_MONO_PWR_EN == !(s_q[15] | s_q[11]) &&
    O_ADC_PWR_EN == !(s_q[15] | s_q[9])) else $error("path enable wrong");
  a_input_path: assert property (O_INPUT_PATH_PWR_EN == (O_MONO_PWR_EN | O_ADC_PWR_EN))
    else $error("input path wrong");
  a_misc_bits: assert property (O_OSC_EN == s_q[5] && O_CLKBUF_EN == s_q[4] &&
    O_EFFECTS_EN == s_q[1] && O_DEEMPH_EN == s_q[0] && O_MIC_BIAS_EN == !(s_q[15] | s_q[6]))
    else $error("misc enable wrong");
  a_vcm_release: assert property ((s_q[14] && !nd) [*3] |-> !O_VCM_PWR_EN)
    else $error("vcm not released");
  a_vcm_hold: assert property (!s_q[15] && !s_q[14] && O_VCM_PWR_EN |=>
    O_VCM_PWR_EN || s_q[15] || s_q[14]) else $error("vcm dropped");
  a_sync_off: assert property (s_q[3] [*3] |-> !O_CONV_HALT)
    else $error("halt with monitor off");
endmodule
bind apmc_top apmc_top_props #(.VCM_STARTUP_CYCLES(VCM_STARTUP_CYCLES)) u_props (
  .I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
  .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
  .O_WB_ACK(O_WB_ACK), .O_BYPASS_PWR_EN(O_BYPASS_PWR_EN), .O_HP_AMP_PWR_EN(O_HP_AMP_PWR_EN),
  .O_MONO_PWR_EN(O_MONO_PWR_EN), .O_DAC_PWR_EN(O_DAC_PWR_EN), .O_ADC_PWR_EN(O_ADC_PWR_EN),
  .O_INPUT_PATH_PWR_EN(O_INPUT_PATH_PWR_EN), .O_VCM_PWR_EN(O_VCM_PWR_EN),
  .O_MIC_BIAS_EN(O_MIC_BIAS_EN), .O_OSC_EN(O_OSC_EN), .O_CLKBUF_EN(O_CLKBUF_EN),
  .O_EFFECTS_EN(O_EFFECTS_EN), .O_DEEMPH_EN(O_DEEMPH_EN), .O_CONV_HALT(O_CONV_HALT));

//--- verification/tb_audio_power_misc_control.sv
// Testbench for the audio power control block.
// Assumes a one-cycle registered Wishbone ack.
`timescale 1ns/1ps
module tb_audio_power_misc_control
  import apmc_pkg::*;
;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, lr = 1'h0, bk = 1'h0, vb = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0, rdat, r;
  logic ack, bp, hp, mo, dac, adc, inp, common_mode_reference, mic, osc, cb, fx, de, halt;
  logic [10:0] pw;
  logic [15:0] tv [4] = '{16'h7F20, 16'h0F60, 16'h3733, 16'h3D33};
  logic [10:0] te [4] = '{11'h018, 11'h608, 11'h13F, 11'h07F};
  int err_total = 0;
  int num_checks = 0;
  assign pw = {bp, hp, mo, dac, adc, inp, mic, osc, cb, fx, de};
  // Short start-up count keeps the done-flag wait brief
  apmc_top #(.VCM_STARTUP_CYCLES(200)) DUT (
    .I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wd), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_LRCLK(lr), .I_BCLK(bk), .I_VOL_STEP_BUSY(vb), .O_BYPASS_PWR_EN(bp),
    .O_HP_AMP_PWR_EN(hp), .O_MONO_PWR_EN(mo), .O_DAC_PWR_EN(dac), .O_ADC_PWR_EN(adc),
    .O_INPUT_PATH_PWR_EN(inp), .O_VCM_PWR_EN(common_mode_reference), .O_MIC_BIAS_EN(mic), .O_OSC_EN(osc),
    .O_CLKBUF_EN(cb), .O_EFFECTS_EN(fx), .O_DEEMPH_EN(de), .O_CONV_HALT(halt));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] m,
    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= m;
    wd <= d;
    do @(posedge clk); while (ack !== 1'h1);
    r = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask
  // Bit clock rises per frame clock period
  task automatic frame(input int n);
    @(posedge clk);
    lr <= 1'h1;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk);
      bk <= 1'h1;
      repeat (4) @(posedge clk);
      bk <= 1'h0;
      lr <= 1'h0;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    chk("reset outputs", pw, 32'h008);
    wb(1'h0, 8'h14, 4'hF, 32'h0);
    chk("reset image", r, 32'hFFA4);
    wb(1'h0, 8'h14, 4'hF, 32'h0);
    chk("flag cleared", r[2], 1'h0);
    wb(1'h0, 8'h18, 4'hF, 32'h0);
    chk("step done", r, 32'h1);
    vb <= 1'h1;
    wb(1'h0, 8'h18, 4'hF, 32'h0);
    chk("step busy", r, 32'h0);
    vb <= 1'h0;
    wb(1'h0, 8'h3C, 4'hF, 32'h0);
    chk("unmapped", r, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      wb(1'h1, 8'h14, 4'h3, {16'h0, tv[i]});
      chk("outputs", pw, te[i]);
    end
    wb(1'h1, 8'h14, 4'h3, 32'h3933);
    chk("dac path", pw, 32'h0FF);
    chk("vcm on", common_mode_reference, 1'h1);
    wb(1'h0, 8'h14, 4'hF, 32'h0);
    chk("done pending", r[7], 1'h0);
    repeat (300) @(posedge clk);
    wb(1'h0, 8'h14, 4'hF, 32'h0);
    chk("done set", r, 32'h39B3);
    wb(1'h1, 8'h14, 4'h3, 32'h3F33);
    chk("vcm held", common_mode_reference, 1'h1);
    wb(1'h1, 8'h14, 4'h3, 32'h7F33);
    repeat (4) @(posedge clk);
    chk("vcm off", common_mode_reference, 1'h0);
    $display("power test done");
    wb(1'h1, 8'h14, 4'h3, 32'h3933);
    wb(1'h1, 8'h14, 4'h2, 32'hB900);
    chk("master down", pw, 32'h00F);
    wb(1'h0, 8'h14, 4'hF, 32'h0);
    chk("bits kept", r & 32'hFF7B, 32'hB933);
    wb(1'h1, 8'h14, 4'h2, 32'h3900);
    chk("master up", pw, 32'h0FF);
    $display("master test done");
    frame(4);
    frame(4);
    frame(6);
    frame(6);
    chk("halt", halt, 1'h1);
    wb(1'h0, 8'h14, 4'hF, 32'h0);
    chk("unsynced", r[2], 1'h1);
    frame(6);
    chk("resynced", halt, 1'h0);
    wb(1'h0, 8'h14, 4'hF, 32'h0);
    chk("sticky", r[2], 1'h1);
    wb(1'h0, 8'h14, 4'hF, 32'h0);
    chk("read clear", r[2], 1'h0);
    $display("sync test done");
    wb(1'h1, 8'h14, 4'h1, 32'h1B);
    chk("osc off", osc, 1'h0);
    frame(4);
    frame(6);
    frame(6);
    chk("halt off", halt, 1'h0);
    wb(1'h0, 8'h14, 4'hF, 32'h0);
    chk("flag off", r[2], 1'h0);
    $display("monitor off test done");
    complete_run();
  end
endmodule
